//--- hdl/hot_standby_link_failover.v
// hot-standby failover between a fibre and a copper ethernet channel
`timescale 1ns/1ps
`include "failover_defines.vh"
module hot_standby_link_failover
(
	// clock and reset
	input  wire                 clk_sys,
	input  wire                 rst_b,
	// link status from the two phys
	input  wire                 link_up_fibre,
	input  wire                 link_up_copper,
	// settings
	input  wire [`TMO_W-1:0]    timeout_ticks,
	input  wire [7:0]           tick_div,
	input  wire                 initial_channel,
	// controller handshakes
	input  wire                 reconfig_done,
	// status and control outputs
	output reg                  active_channel,
	output reg                  network_card_fail_alarm,
	output reg                  standby_link_ok,
	output reg                  timer_running,
	output reg                  reconfig_start,
	output reg                  renegotiate_start,
	output reg                  swap_event
);
	localparam ST_MON    = 5'b00001;
	localparam ST_TIMER  = 5'b00010;
	localparam ST_RECONF = 5'b00100;
	localparam ST_RENEG  = 5'b01000;
	localparam ST_INIT   = 5'b10000;

	reg [4:0]          state;
	reg [4:0]          next_state;
	reg [`TMO_W-1:0]   timer;
	reg [`RECONF_W-1:0] reconf_cnt;
	wire               tick;
	wire               active_up;
	wire               standby_up;
	wire               timer_expired;
	wire               fail_seen;
	wire               swap_now;
	wire               resume_mon;
	wire               reconf_exit;
	wire [`TMO_W-1:0]  load_value;

	// fibre or copper selected by the active channel bit
	assign active_up  = (active_channel == `CH_FIBRE) ? link_up_fibre : link_up_copper;
	assign standby_up = (active_channel == `CH_FIBRE) ? link_up_copper : link_up_fibre;

	tick_divider u_div
	(
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.run       (timer_running),
		.div_ratio (tick_div),
		.tick      (tick)
	);

	// next state
	always @*
	begin
		next_state = state;
		case (state)
			ST_INIT:
			begin
				// one edge to catch the channel strap
				next_state = ST_MON;
			end
			ST_MON:
			begin
				if (!active_up)
					next_state = ST_TIMER;
			end
			ST_TIMER:
			begin
				if (active_up)
					next_state = ST_MON;
				else if (timer_expired)
					next_state = standby_up ? ST_RECONF : ST_MON;
			end
			ST_RECONF:
			begin
				// fallback count keeps a silent controller from hanging the swap
				if (reconfig_done || (reconf_cnt == `RECONF_CYCLES))
					next_state = ST_RENEG;
			end
			ST_RENEG:
			begin
				next_state = ST_MON;
			end
			default:
			begin
				next_state = ST_INIT;
			end
		endcase
	end

	// decisions shared by the state register and the outputs
	assign timer_expired = tick && (timer <= `TMO_W'h0001);
	assign fail_seen     = (state == ST_MON) && !active_up;
	assign swap_now      = (state == ST_TIMER) && (next_state == ST_RECONF);
	assign resume_mon    = (state == ST_TIMER) && (next_state == ST_MON);
	assign reconf_exit   = (state == ST_RECONF) && (next_state == ST_RENEG);
	// zero setting taken as one tick so the timer always ends
	assign load_value    = (timeout_ticks == `TMO_W'h0000) ? `TMO_W'h0001 : timeout_ticks;

	// state register
	always @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= ST_INIT;
		end
		else
		begin
			state <= next_state;
		end
	end

	// failover timer: loaded on the first failed sample, counted on divider ticks
	always @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			timer <= `TMO_RESET;
		end
		else if (fail_seen)
		begin
			timer <= load_value;
		end
		else if ((state == ST_TIMER) && (next_state == ST_TIMER) && tick)
		begin
			timer <= timer - `TMO_W'h0001;
		end
	end

	// timer running flag, also the divider's run input
	always @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			timer_running <= 1'b0;
		end
		else
		begin
			case (state)
				ST_MON:
				begin
					if (!active_up)
						timer_running <= 1'b1;
				end
				ST_TIMER:
				begin
					// dropped for a cycle even with both down; the monitor reloads it
					if (next_state != ST_TIMER)
						timer_running <= 1'b0;
				end
				default:
				begin
					timer_running <= 1'b0;
				end
			endcase
		end
	end

	// reconfiguration wait counter
	always @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			reconf_cnt <= {`RECONF_W{1'b0}};
		end
		else if (swap_now)
		begin
			reconf_cnt <= {`RECONF_W{1'b0}};
		end
		else if (state == ST_RECONF)
		begin
			reconf_cnt <= reconf_cnt + `RECONF_W'h1;
		end
	end

	// channel selection: strap after reset, flipped on a swap
	always @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			active_channel <= `CH_FIBRE;
		end
		else if (state == ST_INIT)
		begin
			// strap caught after reset release, not under it
			active_channel <= initial_channel;
		end
		else if (swap_now)
		begin
			active_channel <= ~active_channel;
		end
	end

	// alarm follows the active link only where the state machine looks at it
	always @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			network_card_fail_alarm <= 1'b0;
		end
		else
		begin
			case (state)
				ST_MON:
				begin
					network_card_fail_alarm <= !active_up;
				end
				ST_TIMER:
				begin
					// alarm stays up if both links are down
					if (resume_mon)
						network_card_fail_alarm <= !active_up;
				end
				ST_RENEG:
				begin
					// new channel judged once renegotiation has been started
					network_card_fail_alarm <= !active_up;
				end
				default:
				begin
					network_card_fail_alarm <= network_card_fail_alarm;
				end
			endcase
		end
	end

	// one-cycle pulses to the ethernet controller, plus the standby sample
	always @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			swap_event        <= 1'b0;
			reconfig_start    <= 1'b0;
			renegotiate_start <= 1'b0;
			standby_link_ok   <= 1'b0;
		end
		else
		begin
			swap_event        <= swap_now;
			reconfig_start    <= swap_now;
			renegotiate_start <= reconf_exit;
			standby_link_ok   <= standby_up;
		end
	end
endmodule // hot_standby_link_failover

//--- hdl/failover_defines.vh
// constants for the hot-standby link failover controller
`ifndef FAILOVER_DEFINES_VH
`define FAILOVER_DEFINES_VH
`define CH_FIBRE        1'b0
`define CH_COPPER       1'b1
`define TMO_W           16
`define TMO_RESET       16'h0064
`define RECONF_W        4
`define RECONF_CYCLES   4'h8
`endif

//--- hdl/tick_divider.v
// divider making a one-cycle tick for the failover timer
`timescale 1ns/1ps
module tick_divider
(
	// clock and reset
	input  wire        clk_sys,
	input  wire        rst_b,
	// divide control
	input  wire        run,
	input  wire [7:0]  div_ratio,
	// tick out
	output reg         tick
);
	reg [7:0] cnt;

	// count down while running, restart when idle so each wait starts fresh
	always @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt  <= 8'h00;
			tick <= 1'b0;
		end
		else if (!run)
		begin
			cnt  <= div_ratio;
			tick <= 1'b0;
		end
		else if (cnt == 8'h00)
		begin
			cnt  <= div_ratio;
			tick <= 1'b1;
		end
		else
		begin
			cnt  <= cnt - 8'h01;
			tick <= 1'b0;
		end
	end
endmodule // tick_divider

//--- bench/failover_assertions.sv
// checker for the failover controller
`timescale 1ns/1ps
module failover_chk
(
	// clock and reset
	input wire clk_sys,
	input wire rst_b,
	// link status
	input wire link_up_fibre,
	input wire link_up_copper,
	// controller outputs
	input wire active_channel,
	input wire network_card_fail_alarm,
	input wire timer_running,
	input wire reconfig_start,
	input wire renegotiate_start,
	input wire swap_event
);
	// links of the current and the spare channel
	wire act = active_channel ? link_up_copper : link_up_fibre;
	wire sby = active_channel ? link_up_fibre : link_up_copper;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// skip the init edge, where the channel is still being latched
	sequence s_down; $past(rst_b, 2) && !network_card_fail_alarm && !act; endsequence
	chk_alarm_raise: assert property (s_down |=> network_card_fail_alarm) else $error("no alarm");
	chk_timer_start: assert property (s_down |=> timer_running) else $error("no timer");
	chk_timer_alarm: assert property (timer_running |-> network_card_fail_alarm) else $error("alarm off");
	chk_keep_up: assert property (timer_running && act |=> !swap_event) else $error("swap on up");
	chk_keep_both: assert property (!link_up_fibre && !link_up_copper |=> !swap_event) else $error("swap on both");
	chk_swap_cond: assert property (swap_event |-> $past(sby) && !$past(act) && $past(timer_running)) else $error("bad swap");
	chk_swap_flip: assert property (swap_event |-> active_channel != $past(active_channel)) else $error("no flip");
	chk_reneg_after: assert property (reconfig_start |-> ##[1:10] renegotiate_start) else $error("no reneg");
endmodule // failover_chk
bind hot_standby_link_failover failover_chk u_chk
(
	.clk_sys                 (clk_sys),
	.rst_b                   (rst_b),
	.link_up_fibre           (link_up_fibre),
	.link_up_copper          (link_up_copper),
	.active_channel          (active_channel),
	.network_card_fail_alarm (network_card_fail_alarm),
	.timer_running           (timer_running),
	.reconfig_start          (reconfig_start),
	.renegotiate_start       (renegotiate_start),
	.swap_event              (swap_event)
);

//--- bench/link_partner.sv
// far switch ends of both channels plus the controller ack
`timescale 1ns/1ps
module link_partner #(parameter DLY = 2)
(
	// clock
	input wire clk_sys,
	// cable cuts from the bench
	input wire cut_f,
	input wire cut_c,
	// controller handshake
	input wire reconfig_start,
	// link status and controller ack
	output reg link_up_fibre = 1'b1,
	output reg link_up_copper = 1'b1,
	output reg reconfig_done = 1'b0
);
	integer n = 0;
	// links follow the cuts a cycle late, ack comes DLY clocks after the request
	always @(posedge clk_sys)
	begin
		link_up_fibre <= #10 !cut_f;
		link_up_copper <= #10 !cut_c;
		n <= reconfig_start ? DLY : (n > 0 ? n - 1 : 0);
		reconfig_done <= #10 (n == 1);
	end
endmodule // link_partner

//--- bench/tb_top.sv
// bench for the hot-standby failover controller
`timescale 1ns/1ps
module tb_top;
	reg clk_sys = 1'b0, rst_b = 1'b0, cut_f = 1'b0, cut_c = 1'b0;
	reg [15:0] timeout_ticks = 16'h0040;
	wire [7:0] tick_div = 8'h01;
	reg initial_channel = 1'b0;
	wire link_up_fibre, link_up_copper, reconfig_done, active_channel, network_card_fail_alarm;
	wire standby_link_ok, timer_running, reconfig_start, renegotiate_start, swap_event;
	integer n_fail = 0, num_checks = 0;
	initial forever #50 clk_sys = ~clk_sys;
	link_partner u_far
	(
		.clk_sys        (clk_sys),
		.cut_f          (cut_f),
		.cut_c          (cut_c),
		.reconfig_start (reconfig_start),
		.link_up_fibre  (link_up_fibre),
		.link_up_copper (link_up_copper),
		.reconfig_done  (reconfig_done)
	);
	hot_standby_link_failover u_dut
	(
		.clk_sys                 (clk_sys),
		.rst_b                   (rst_b),
		.link_up_fibre           (link_up_fibre),
		.link_up_copper          (link_up_copper),
		.timeout_ticks           (timeout_ticks),
		.tick_div                (tick_div),
		.initial_channel         (initial_channel),
		.reconfig_done           (reconfig_done),
		.active_channel          (active_channel),
		.network_card_fail_alarm (network_card_fail_alarm),
		.standby_link_ok         (standby_link_ok),
		.timer_running           (timer_running),
		.reconfig_start          (reconfig_start),
		.renegotiate_start       (renegotiate_start),
		.swap_event              (swap_event)
	);
	task ck(input string nm, input logic e, g);
		num_checks++;
		if (e !== g)
		begin
			$display("wrong value %s exp %b got %b", nm, e, g);
			n_fail++;
		end
	endtask
	// counts compared as four-state integers so an unknown fails
	task ckn(input string nm, input integer e, g);
		num_checks++;
		if (e !== g)
		begin
			$display("wrong value %s exp %0d got %0d", nm, e, g);
			n_fail++;
		end
	endtask
	// inputs move 10 ns after the edge
	task cyc(input integer k); repeat (k) @(posedge clk_sys); #10; endtask
	task summarize;
		if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// short fibre outage well inside the timeout, then wait past it: no swap
	task t_recover;
		timeout_ticks = 16'h0008;
		cut_f = 1; cyc(4);
		ck("alarm", 1, network_card_fail_alarm);
		ck("timer", 1, timer_running);
		ck("standby", 1, standby_link_ok);
		cut_f = 0; cyc(20);
		ck("channel", 0, active_channel);
		ck("alarm", 0, network_card_fail_alarm);
	endtask
	// lasting outage with a good spare: swap away from the given channel
	task t_swap(input logic from);
		integer i, n_sw, n_rc, n_rn, i_rc, i_rn;
		n_sw = 0;
		n_rc = 0;
		n_rn = 0;
		i_rc = 0;
		i_rn = 0;
		timeout_ticks = 16'h0004; cut_f = !from; cut_c = from;
		// pulses sampled once per cycle while they stand
		for (i = 1; i <= 40; i++)
		begin
			cyc(1);
			n_sw += swap_event;
			n_rc += reconfig_start;
			n_rn += renegotiate_start;
			if (reconfig_start === 1'b1) i_rc = i;
			if (renegotiate_start === 1'b1) i_rn = i;
		end
		ck("channel", !from, active_channel);
		ck("alarm", 0, network_card_fail_alarm);
		ckn("swap pulses", 1, n_sw);
		ckn("reconfig pulses", 1, n_rc);
		ckn("renegotiate pulses", 1, n_rn);
		ck("renegotiate after reconfig", 1, i_rn > i_rc);
		cut_f = 0; cut_c = 0; cyc(2);
	endtask
	// both down across the timeout: stay put
	task t_both;
		cut_f = 1; cut_c = 1; cyc(30);
		ck("channel", 0, active_channel);
		ck("alarm", 1, network_card_fail_alarm);
		ck("standby", 0, standby_link_ok);
		cut_f = 0; cut_c = 0; cyc(5);
	endtask
	// mid-run reset with the copper strap, then a short copper outage
	task t_reset;
		initial_channel = 1; rst_b = 0; cyc(2);
		ck("channel", 0, active_channel);
		ck("alarm", 0, network_card_fail_alarm);
		rst_b = 1; cyc(3);
		ck("channel", 1, active_channel);
		cut_c = 1; cyc(4);
		ck("alarm", 1, network_card_fail_alarm);
		cut_c = 0; cyc(20);
		ck("channel", 1, active_channel);
		ck("alarm", 0, network_card_fail_alarm);
	endtask
	initial
	begin
		cyc(6); rst_b = 1; cyc(3);
		t_recover; t_swap(0); t_swap(1); t_both; t_reset;
		summarize;
	end
	// run needs about 18 us
	initial
	begin
		#50000; n_fail++; summarize;
	end
endmodule // tb_top
